/* File: rtl/ac_line_cfg_pkg.sv */
// Constants and types for the ac line and soft start configuration block
package ac_line_cfg_pkg;

  localparam logic [15:0] ADDR_THR_SET    = 16'hFE25;
  localparam logic [15:0] ADDR_THR_READ   = 16'hFE26;
  localparam logic [15:0] ADDR_MIN_PERIOD = 16'hFE27;
  localparam logic [15:0] ADDR_MAX_PERIOD = 16'hFE28;
  localparam logic [15:0] ADDR_GAIN_LOW   = 16'hFE29;
  localparam logic [15:0] ADDR_ZERO_LOW   = 16'hFE2A;
  localparam logic [15:0] ADDR_GAIN_HIGH  = 16'hFE2B;
  localparam logic [15:0] ADDR_ZERO_HIGH  = 16'hFE2C;
  localparam logic [15:0] ADDR_SOFT_START = 16'hFE2D;

  localparam logic [7:0] RST_THR_SET    = 8'h80;
  localparam logic [7:0] RST_MIN_PERIOD = 8'h55;
  localparam logic [7:0] RST_MAX_PERIOD = 8'h99;
  localparam logic [7:0] RST_COEF       = 8'h00;
  localparam logic [7:0] RST_SOFT_START = 8'h00;

  localparam int THR_AUTO_BIT  = 7;
  localparam int SS_DELAY_LSB  = 3;
  localparam int SS_DELAY_MSB  = 5;
  localparam int SS_TIME_MSB   = 2;
  localparam logic [7:0] SS_WRITE_MASK = 8'h3F;

  localparam real CLK_PERIOD_NS   = 5.0;
  localparam real PERIOD_UNIT_US  = 163.84;
  localparam real MS_UNIT_MS      = 1.0;
  localparam int  PERIOD_UNIT_CYC = int'(PERIOD_UNIT_US * 1000.0 / CLK_PERIOD_NS);
  localparam int  MS_UNIT_CYC     = int'(MS_UNIT_MS * 1000000.0 / CLK_PERIOD_NS);

  localparam logic [6:0] HIGH_LINE_LEVEL_DFLT = 7'h50;
  // Mid scale start, so a flat input after reset gives no false crossing
  localparam logic [6:0] RST_AUTO_THR         = 7'h3F;

  typedef enum logic [2:0] {
    SS_OFF,
    SS_INRUSH_WAIT,
    SS_START_WAIT,
    SS_RAMP,
    SS_DONE
  } ss_state_type;

  function automatic logic [9:0] soft_start_ms(input logic [2:0] code);
    logic [9:0] ms;
    ms = 10'h070;
    case (code)
      3'h0:    ms = 10'h070;
      3'h1:    ms = 10'h0A8;
      3'h2:    ms = 10'h0E0;
      3'h3:    ms = 10'h118;
      3'h4:    ms = 10'h188;
      3'h5:    ms = 10'h1F8;
      3'h6:    ms = 10'h268;
      3'h7:    ms = 10'h2D8;
      default: ms = 10'h070;
    endcase
    return ms;
  endfunction

endpackage

/* File: rtl/line_period_meter.sv */
// Threshold crossing, ac line period measurement and automatic threshold
`timescale 1ns/1ps
module line_period_meter #(
  parameter int TICK_CYCLES = ac_line_cfg_pkg::PERIOD_UNIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [6:0] vinLevel,
  input  wire logic [6:0] threshold,
  input  wire logic [7:0] minPeriod,
  input  wire logic [7:0] maxPeriod,
  output logic            crossing,
  output logic            cycleOk,
  output logic            cycleBad,
  output logic      [7:0] period_ff,
  output logic      [6:0] cyclePeak_ff,
  output logic      [6:0] autoThr_ff
);

  logic        above_ff;
  logic [15:0] tickCnt_ff;
  logic [7:0]  periodCnt_ff;
  logic [6:0]  peak_ff;
  logic [6:0]  trough_ff;
  logic        inRange;
  logic [7:0]  midSum;

  // Rising crossing marks the start of a full line cycle
  assign crossing = (vinLevel >= threshold) && !above_ff;
  assign inRange  = (periodCnt_ff >= minPeriod) && (periodCnt_ff <= maxPeriod);
  assign cycleOk  = crossing && inRange;
  assign cycleBad = crossing && !inRange;
  assign midSum   = {1'b0, peak_ff} + {1'b0, trough_ff};

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      above_ff <= 1'b0;
    else
      above_ff <= (vinLevel >= threshold);
  end

  // Counter saturates so a dead line reads as too long, never wraps short
  always_ff @(posedge sys_clk)
  begin
    if (srst || crossing)
    begin
      tickCnt_ff   <= 16'h0000;
      periodCnt_ff <= 8'h00;
    end
    else if (tickCnt_ff == 16'(TICK_CYCLES - 1))
    begin
      tickCnt_ff <= 16'h0000;
      if (periodCnt_ff != 8'hFF)
        periodCnt_ff <= periodCnt_ff + 8'h01;
    end
    else
      tickCnt_ff <= tickCnt_ff + 16'h0001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      period_ff <= 8'h00;
    else if (cycleOk)
      period_ff <= periodCnt_ff;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      peak_ff      <= 7'h00;
      trough_ff    <= 7'h7F;
      cyclePeak_ff <= 7'h00;
      autoThr_ff   <= ac_line_cfg_pkg::RST_AUTO_THR;
    end
    else if (crossing)
    begin
      peak_ff      <= vinLevel;
      trough_ff    <= vinLevel;
      cyclePeak_ff <= peak_ff;
      autoThr_ff   <= midSum[7:1];
    end
    else
    begin
      if (vinLevel > peak_ff)
        peak_ff <= vinLevel;
      if (vinLevel < trough_ff)
        trough_ff <= vinLevel;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_period_window: assert property (cycleOk |=>
    (period_ff >= $past(minPeriod)) && (period_ff <= $past(maxPeriod)))
    else $error("accepted period outside limits");
  a_crossing_edge: assert property (crossing |->
    ##1 ($past(vinLevel) >= $past(threshold)) && above_ff)
    else $error("crossing without threshold rise");
  c_bad_period: cover property (cycleBad);

endmodule

/* File: rtl/ac_line_softstart_config.sv */
// Register bank for line threshold, period limits, current loop and soft start
`timescale 1ns/1ps
module ac_line_softstart_config #(
  parameter int         TICK_CYCLES     = ac_line_cfg_pkg::PERIOD_UNIT_CYC,
  parameter int         MS_CYCLES       = ac_line_cfg_pkg::MS_UNIT_CYC,
  parameter logic [6:0] HIGH_LINE_LEVEL = ac_line_cfg_pkg::HIGH_LINE_LEVEL_DFLT
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata_ff,
  output logic             regRdValid_ff,
  input  wire logic [6:0]  vinLevel,
  input  wire logic        inputUndervoltage,
  input  wire logic [2:0]  inrushDelayCycles,
  output logic             zeroCross,
  output logic             periodValid,
  output logic             periodInvalid,
  output logic      [7:0]  linePeriod_ff,
  output logic             highLine_ff,
  output logic      [7:0]  gainCoef_ff,
  output logic      [7:0]  zeroCoef_ff,
  output logic             inrushOn_ff,
  output logic             softStartOn_ff,
  output logic             softStartDone_ff
);

  logic [7:0] thrSet_ff;
  logic [7:0] minPeriod_ff;
  logic [7:0] maxPeriod_ff;
  logic [7:0] gainLow_ff;
  logic [7:0] zeroLow_ff;
  logic [7:0] gainHigh_ff;
  logic [7:0] zeroHigh_ff;
  logic [7:0] softStart_ff;

  logic       autoMode;
  logic [6:0] autoThr;
  logic [6:0] thrSelected;
  logic [6:0] cyclePeak;
  logic       cycleOk;

  ac_line_cfg_pkg::ss_state_type state_ff;
  ac_line_cfg_pkg::ss_state_type nxt_state;
  logic [2:0]  cycleCnt_ff;
  logic [2:0]  nxt_cycleCnt;
  logic [17:0] msTickCnt_ff;
  logic [9:0]  msElapsed_ff;
  logic        msTick;
  logic [2:0]  ssDelay;
  logic [9:0]  ssDuration;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] target);
    return addr == target;
  endfunction

  // Register writes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      thrSet_ff    <= ac_line_cfg_pkg::RST_THR_SET;
      minPeriod_ff <= ac_line_cfg_pkg::RST_MIN_PERIOD;
      maxPeriod_ff <= ac_line_cfg_pkg::RST_MAX_PERIOD;
      gainLow_ff   <= ac_line_cfg_pkg::RST_COEF;
      zeroLow_ff   <= ac_line_cfg_pkg::RST_COEF;
      gainHigh_ff  <= ac_line_cfg_pkg::RST_COEF;
      zeroHigh_ff  <= ac_line_cfg_pkg::RST_COEF;
      softStart_ff <= ac_line_cfg_pkg::RST_SOFT_START;
    end
    else if (regWrite)
    begin
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_THR_SET))
        thrSet_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_MIN_PERIOD))
        minPeriod_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_MAX_PERIOD))
        maxPeriod_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_GAIN_LOW))
        gainLow_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_ZERO_LOW))
        zeroLow_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_GAIN_HIGH))
        gainHigh_ff <= regWdata;
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_ZERO_HIGH))
        zeroHigh_ff <= regWdata;
      // Reserved bits stay zero so readback never shows stale writes
      if (hit(regAddr, ac_line_cfg_pkg::ADDR_SOFT_START))
        softStart_ff <= regWdata & ac_line_cfg_pkg::SS_WRITE_MASK;
    end
  end

  // Register reads; unmapped offsets answer zero
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      regRdata_ff   <= 8'h00;
      regRdValid_ff <= 1'b0;
    end
    else
    begin
      regRdValid_ff <= regRead;
      if (regRead)
      begin
        if (hit(regAddr, ac_line_cfg_pkg::ADDR_THR_SET))
          regRdata_ff <= thrSet_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_THR_READ))
          regRdata_ff <= {1'b0, autoMode ? autoThr : 7'h00};
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_MIN_PERIOD))
          regRdata_ff <= minPeriod_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_MAX_PERIOD))
          regRdata_ff <= maxPeriod_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_GAIN_LOW))
          regRdata_ff <= gainLow_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_ZERO_LOW))
          regRdata_ff <= zeroLow_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_GAIN_HIGH))
          regRdata_ff <= gainHigh_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_ZERO_HIGH))
          regRdata_ff <= zeroHigh_ff;
        else if (hit(regAddr, ac_line_cfg_pkg::ADDR_SOFT_START))
          regRdata_ff <= softStart_ff;
        else
          regRdata_ff <= 8'h00;
      end
    end
  end

  // Threshold source selection
  assign autoMode    = thrSet_ff[ac_line_cfg_pkg::THR_AUTO_BIT];
  assign thrSelected = autoMode ? autoThr : thrSet_ff[6:0];

  line_period_meter #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_meter (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .vinLevel     (vinLevel),
    .threshold    (thrSelected),
    .minPeriod    (minPeriod_ff),
    .maxPeriod    (maxPeriod_ff),
    .crossing     (zeroCross),
    .cycleOk      (cycleOk),
    .cycleBad     (periodInvalid),
    .period_ff    (linePeriod_ff),
    .cyclePeak_ff (cyclePeak),
    .autoThr_ff   (autoThr)
  );

  assign periodValid = cycleOk;

  // Class changes only on an accepted cycle so coefficients never swap mid-cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      highLine_ff <= 1'b0;
    else if (cycleOk)
      highLine_ff <= (cyclePeak >= HIGH_LINE_LEVEL);
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      gainCoef_ff <= ac_line_cfg_pkg::RST_COEF;
      zeroCoef_ff <= ac_line_cfg_pkg::RST_COEF;
    end
    else if (highLine_ff)
    begin
      gainCoef_ff <= gainHigh_ff;
      zeroCoef_ff <= zeroHigh_ff;
    end
    else
    begin
      gainCoef_ff <= gainLow_ff;
      zeroCoef_ff <= zeroLow_ff;
    end
  end

  // Inrush and soft start sequencing
  assign ssDelay    = softStart_ff[ac_line_cfg_pkg::SS_DELAY_MSB:ac_line_cfg_pkg::SS_DELAY_LSB];
  assign ssDuration = ac_line_cfg_pkg::soft_start_ms(softStart_ff[ac_line_cfg_pkg::SS_TIME_MSB:0]);
  assign msTick     = (state_ff == ac_line_cfg_pkg::SS_RAMP) &&
                      (msTickCnt_ff == 18'(MS_CYCLES - 1));

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cycleCnt = cycleCnt_ff;
    case (state_ff)
      ac_line_cfg_pkg::SS_OFF:
      begin
        nxt_cycleCnt = 3'h0;
        if (!inputUndervoltage)
          nxt_state = ac_line_cfg_pkg::SS_INRUSH_WAIT;
      end
      ac_line_cfg_pkg::SS_INRUSH_WAIT:
      begin
        if (cycleCnt_ff == inrushDelayCycles)
        begin
          nxt_state    = ac_line_cfg_pkg::SS_START_WAIT;
          nxt_cycleCnt = 3'h0;
        end
        else if (cycleOk)
          nxt_cycleCnt = cycleCnt_ff + 3'h1;
      end
      ac_line_cfg_pkg::SS_START_WAIT:
      begin
        if (cycleCnt_ff == ssDelay)
        begin
          nxt_state    = ac_line_cfg_pkg::SS_RAMP;
          nxt_cycleCnt = 3'h0;
        end
        else if (cycleOk)
          nxt_cycleCnt = cycleCnt_ff + 3'h1;
      end
      ac_line_cfg_pkg::SS_RAMP:
      begin
        if (msTick && (msElapsed_ff == ssDuration - 10'h001))
          nxt_state = ac_line_cfg_pkg::SS_DONE;
      end
      ac_line_cfg_pkg::SS_DONE:
        nxt_state = ac_line_cfg_pkg::SS_DONE;
      default:
        nxt_state = ac_line_cfg_pkg::SS_OFF;
    endcase
    // Undervoltage aborts any stage and restarts the sequence
    if (inputUndervoltage)
    begin
      nxt_state    = ac_line_cfg_pkg::SS_OFF;
      nxt_cycleCnt = 3'h0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_ff    <= ac_line_cfg_pkg::SS_OFF;
      cycleCnt_ff <= 3'h0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cycleCnt_ff <= nxt_cycleCnt;
    end
  end

  // Millisecond timebase runs only while ramping
  always_ff @(posedge sys_clk)
  begin
    if (srst || (state_ff != ac_line_cfg_pkg::SS_RAMP))
    begin
      msTickCnt_ff <= 18'h00000;
      msElapsed_ff <= 10'h000;
    end
    else if (msTick)
    begin
      msTickCnt_ff <= 18'h00000;
      msElapsed_ff <= msElapsed_ff + 10'h001;
    end
    else
      msTickCnt_ff <= msTickCnt_ff + 18'h00001;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      inrushOn_ff      <= 1'b0;
      softStartOn_ff   <= 1'b0;
      softStartDone_ff <= 1'b0;
    end
    else
    begin
      inrushOn_ff      <= (nxt_state == ac_line_cfg_pkg::SS_START_WAIT) ||
                          (nxt_state == ac_line_cfg_pkg::SS_RAMP) ||
                          (nxt_state == ac_line_cfg_pkg::SS_DONE);
      softStartOn_ff   <= (nxt_state == ac_line_cfg_pkg::SS_RAMP);
      softStartDone_ff <= (nxt_state == ac_line_cfg_pkg::SS_DONE);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_thr_source: assert property (thrSet_ff[7] |->
    u_meter.threshold == autoThr)
    else $error("threshold source mismatch");
  a_manual_thr: assert property (!autoMode |->
    u_meter.threshold == thrSet_ff[6:0])
    else $error("manual threshold not applied");
  a_readback: assert property (regRead && hit(regAddr, ac_line_cfg_pkg::ADDR_THR_READ)
    |=> regRdValid_ff && regRdata_ff == {1'b0, $past(autoMode) ? $past(autoThr) : 7'h00})
    else $error("threshold readback wrong");
  a_min_write: assert property (regWrite && hit(regAddr, ac_line_cfg_pkg::ADDR_MIN_PERIOD)
    |=> minPeriod_ff == $past(regWdata))
    else $error("minimum period not stored");
  a_max_write: assert property (regWrite && hit(regAddr, ac_line_cfg_pkg::ADDR_MAX_PERIOD)
    |=> maxPeriod_ff == $past(regWdata))
    else $error("maximum period not stored");
  a_low_coef: assert property (!highLine_ff ##1 !highLine_ff |->
    gainCoef_ff == $past(gainLow_ff) && zeroCoef_ff == $past(zeroLow_ff))
    else $error("low-line coefficients not used");
  a_high_coef: assert property (highLine_ff ##1 highLine_ff |->
    gainCoef_ff == $past(gainHigh_ff) && zeroCoef_ff == $past(zeroHigh_ff))
    else $error("high-line coefficients not used");
  a_class_boundary: assert property ($changed(highLine_ff) |-> $past(cycleOk))
    else $error("line class changed off boundary");
  a_inrush_delay: assert property ($rose(inrushOn_ff) |->
    $past(state_ff == ac_line_cfg_pkg::SS_INRUSH_WAIT && cycleCnt_ff == inrushDelayCycles))
    else $error("inrush asserted at wrong count");
  a_inrush_drop: assert property (inputUndervoltage |=> !inrushOn_ff && !softStartOn_ff)
    else $error("inrush held during undervoltage");
  a_start_delay: assert property ($rose(softStartOn_ff) |-> inrushOn_ff &&
    $past(state_ff == ac_line_cfg_pkg::SS_START_WAIT && cycleCnt_ff == ssDelay))
    else $error("soft start began at wrong count");
  a_ramp_length: assert property ($rose(softStartDone_ff) |->
    $past(msElapsed_ff) == $past(ssDuration) - 10'h001 && $past(msTick))
    else $error("soft start duration wrong");

  c_inrush: cover property ($rose(inrushOn_ff));
  c_ramp_done: cover property ($rose(softStartDone_ff));
  c_high_line: cover property ($rose(highLine_ff));
  c_auto_read: cover property (regRead && autoMode &&
    hit(regAddr, ac_line_cfg_pkg::ADDR_THR_READ));

endmodule

/* File: tb/mgmt_host.sv */
// Management link host model: single-byte register writes and reads
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  regRdata_ff,
  input  wire logic        regRdValid_ff,
  output logic      [15:0] regAddr,
  output logic             regWrite,
  output logic             regRead,
  output logic      [7:0]  regWdata
);
  initial
  begin
    regAddr  = 16'h0000;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regWdata = 8'h00;
  end

  // Released address and data show the inverse, not the last value
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regAddr  <= ~a;
    regWdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (regRdValid_ff !== 1'b1 && n < 4);
    d = (regRdValid_ff === 1'b1) ? regRdata_ff : 8'hXX;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for line threshold, period limits, filter sets and soft start
`timescale 1ns/1ps
module tb;
  localparam int TICK = 4;
  localparam int MSC  = 4;
  logic        sys_clk, srst, regWrite, regRead, regRdValid_ff, inputUndervoltage;
  logic        zeroCross, periodValid, periodInvalid, highLine_ff, inrushOn_ff;
  logic        softStartOn_ff, softStartDone_ff, manual;
  logic [15:0] regAddr;
  logic [7:0]  regWdata, regRdata_ff, linePeriod_ff, gainCoef_ff, zeroCoef_ff;
  logic [6:0]  vinLevel, thr, prevVin;
  logic [2:0]  inrushDelayCycles;
  logic [31:0] seed;
  logic [7:0]  mdl [logic [15:0]];
  int          miscompares, checks, cyc, zcnt, vcnt, icnt;
  int          durMs [8] = '{112, 168, 224, 280, 392, 504, 616, 728};

  mgmt_host mgmt_host_i (.sys_clk(sys_clk), .regRdata_ff(regRdata_ff),
    .regRdValid_ff(regRdValid_ff), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata));

  ac_line_softstart_config #(.TICK_CYCLES(TICK), .MS_CYCLES(MSC)) ac_line_softstart_config_i (
    .sys_clk(sys_clk), .srst(srst), .regAddr(regAddr), .regWrite(regWrite),
    .regRead(regRead), .regWdata(regWdata), .regRdata_ff(regRdata_ff),
    .regRdValid_ff(regRdValid_ff), .vinLevel(vinLevel), .inputUndervoltage(inputUndervoltage),
    .inrushDelayCycles(inrushDelayCycles), .zeroCross(zeroCross), .periodValid(periodValid),
    .periodInvalid(periodInvalid), .linePeriod_ff(linePeriod_ff), .highLine_ff(highLine_ff),
    .gainCoef_ff(gainCoef_ff), .zeroCoef_ff(zeroCoef_ff), .inrushOn_ff(inrushOn_ff),
    .softStartOn_ff(softStartOn_ff), .softStartDone_ff(softStartDone_ff));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %0t flag got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    mgmt_host_i.wr(a, d);
    if (a == ac_line_cfg_pkg::ADDR_SOFT_START)
      mdl[a] = d & ac_line_cfg_pkg::SS_WRITE_MASK;
    else if (a != ac_line_cfg_pkg::ADDR_THR_READ && mdl.exists(a))
      mdl[a] = d;
    // Programmed threshold hides the automatic readback
    if (a == ac_line_cfg_pkg::ADDR_THR_SET && !d[7])
      mdl[ac_line_cfg_pkg::ADDR_THR_READ] = 8'h00;
  endtask

  task automatic rdchk(input logic [15:0] a);
    logic [7:0] d;
    mgmt_host_i.rd(a, d);
    chk_reg(d, mdl.exists(a) ? mdl[a] : 8'h00);
  endtask

  // One line cycle: low half then a plateau at the given peak
  task automatic wave(input logic [6:0] pk, input int n);
    repeat (n)
    begin
      vinLevel <= 7'h00;
      repeat (20) @(posedge sys_clk);
      vinLevel <= pk;
      repeat (20) @(posedge sys_clk);
    end
  endtask

  task automatic ramp(input int code);
    int n;
    n = 0;
    inputUndervoltage <= 1'b0;
    while (softStartOn_ff !== 1'b1 && n < 12)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_flag(inrushOn_ff, 1'b1);
    n = 0;
    while (softStartOn_ff === 1'b1 && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk_flag(n >= durMs[code] * MSC - 2 && n <= durMs[code] * MSC + 2, 1'b1);
    chk_flag(softStartDone_ff, 1'b1);
    inputUndervoltage <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk_flag(softStartDone_ff | inrushOn_ff, 1'b0);
  endtask

  // Zero crossing reference, only while the programmed threshold is in force
  always @(posedge sys_clk)
  begin
    if (!srst && manual)
      chk_flag(zeroCross, vinLevel >= thr && prevVin < thr);
    if (!srst && (periodValid === 1'b1 || periodInvalid === 1'b1))
      chk_flag(zeroCross, 1'b1);
    if (zeroCross === 1'b1)
      zcnt++;
    if (periodValid === 1'b1)
      vcnt++;
    if (periodInvalid === 1'b1)
      icnt++;
    prevVin <= vinLevel;
    cyc++;
    if (cyc == 60000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  initial
  begin
    srst = 1'b1;
    vinLevel = 7'h00;
    inputUndervoltage = 1'b1;
    inrushDelayCycles = 3'h0;
    manual = 1'b0;
    thr = 7'h00;
    seed = 32'h1799EAD2;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    mdl[ac_line_cfg_pkg::ADDR_THR_SET] = ac_line_cfg_pkg::RST_THR_SET;
    mdl[ac_line_cfg_pkg::ADDR_THR_READ] = {1'b0, ac_line_cfg_pkg::RST_AUTO_THR};
    mdl[ac_line_cfg_pkg::ADDR_MIN_PERIOD] = ac_line_cfg_pkg::RST_MIN_PERIOD;
    mdl[ac_line_cfg_pkg::ADDR_MAX_PERIOD] = ac_line_cfg_pkg::RST_MAX_PERIOD;
    for (int a = 16'hFE29; a <= 16'hFE2C; a++)
      mdl[a[15:0]] = ac_line_cfg_pkg::RST_COEF;
    mdl[ac_line_cfg_pkg::ADDR_SOFT_START] = ac_line_cfg_pkg::RST_SOFT_START;
    for (int a = 16'hFE24; a <= 16'hFE2E; a++)
      rdchk(a[15:0]);
    for (int a = 16'hFE24; a <= 16'hFE2E; a++)
    begin
      seed = lfsr(seed);
      wr(a[15:0], seed[7:0]);
    end
    for (int a = 16'hFE24; a <= 16'hFE2E; a++)
      rdchk(a[15:0]);
    wr(16'hFE25, 8'h20);
    thr = 7'h20;
    manual = 1'b1;
    wr(16'hFE27, 8'h08);
    wr(16'hFE28, 8'h0D);
    wr(16'hFE29, 8'h11);
    wr(16'hFE2A, 8'h22);
    wr(16'hFE2B, 8'h33);
    wr(16'hFE2C, 8'h44);
    wr(16'hFE2D, 8'h00);
    rdchk(16'hFE26);
    vcnt = 0;
    wave(7'h30, 4);
    chk_flag(vcnt >= 3, 1'b1);
    chk_flag(linePeriod_ff >= 8'h08 && linePeriod_ff <= 8'h0D, 1'b1);
    chk_flag(highLine_ff, 1'b0);
    chk_reg(gainCoef_ff, 8'h11);
    chk_reg(zeroCoef_ff, 8'h22);
    wave(7'h60, 3);
    chk_flag(highLine_ff, 1'b1);
    chk_reg(gainCoef_ff, 8'h33);
    chk_reg(zeroCoef_ff, 8'h44);
    // Upper limit below the real period: every cycle must be refused
    wr(16'hFE28, 8'h05);
    icnt = 0;
    wave(7'h30, 3);
    chk_flag(icnt >= 3, 1'b1);
    chk_flag(highLine_ff, 1'b1);
    chk_flag(linePeriod_ff > 8'h05, 1'b1);
    chk_reg(gainCoef_ff, 8'h33);
    wr(16'hFE28, 8'h0D);
    manual = 1'b0;
    wr(16'hFE25, 8'h80);
    vcnt = 0;
    wave(7'h30, 4);
    chk_flag(vcnt >= 3, 1'b1);
    mdl[ac_line_cfg_pkg::ADDR_THR_READ] = 8'h18;
    rdchk(16'hFE26);
    mdl[ac_line_cfg_pkg::ADDR_THR_READ] = 8'h00;
    wr(16'hFE25, 8'h20);
    manual = 1'b1;
    zcnt = 0;
    wave(7'h1F, 2);
    chk_flag(zcnt == 0, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      wr(16'hFE2D, c[7:0]);
      ramp(c);
    end
    wr(16'hFE2D, 8'h10);
    inrushDelayCycles <= 3'h1;
    wave(7'h30, 1);
    inputUndervoltage <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk_flag(inrushOn_ff, 1'b0);
    wave(7'h30, 1);
    chk_flag(inrushOn_ff, 1'b1);
    chk_flag(softStartOn_ff, 1'b0);
    wave(7'h30, 1);
    chk_flag(softStartOn_ff, 1'b0);
    wave(7'h30, 1);
    chk_flag(softStartOn_ff, 1'b1);
    print_verdict();
  end
endmodule
